// *** logic/smo_cfg.svh ***
/*
 * Constants of the service command block: register offsets, field positions,
 * reset values, characters, error numbers, limits and counts.
 * Assumes nothing; included by the package users.
 */
`ifndef SMO_CFG_SVH
`define SMO_CFG_SVH
// Register offsets (byte addresses)
`define SMO_OFS_CTRL 8'h00
`define SMO_OFS_IRQ_ST 8'h04
`define SMO_OFS_IRQ_MASK 8'h08
`define SMO_OFS_REF 8'h0c
`define SMO_OFS_TRIM0 8'h10
`define SMO_OFS_TRIM5 8'h24
`define SMO_OFS_LAST_ERR 8'h28
// Field positions and reset values
`define SMO_CTRL_EXT_BIT 0
`define SMO_IRQ_DONE_BIT 0
`define SMO_IRQ_ERR_BIT 1
`define SMO_IRQ_CLAMP_BIT 2
`define SMO_CTRL_RST 1'b0
`define SMO_IRQ_MASK_RST 3'h0
// Characters
`define SMO_CH_BS 8'h08
`define SMO_CH_CR 8'h0d
`define SMO_CH_SP 8'h20
`define SMO_CH_COMMA 8'h2c
`define SMO_CH_MINUS 8'h2d
`define SMO_CH_PROMPT 8'h3e
`define SMO_CMD_SHOT 8'h61
`define SMO_CMD_TRIM 8'h62
`define SMO_SEL_GYRO 8'h67
`define SMO_SEL_ACC 8'h61
`define SMO_SEL_REF 8'h72
`define SMO_AX_X 8'h78
`define SMO_AX_Y 8'h79
`define SMO_AX_Z 8'h7a
// Error numbers
`define SMO_E_UNKNOWN 4'h1
`define SMO_E_COUNT 4'h2
`define SMO_E_INVALID 4'h3
`define SMO_E_CLAMP 4'h8
// Sizes, counts and trim limits in LSB
`define SMO_BUF_DEPTH 7'd80
`define SMO_MAX_DIGITS 4'd9
`define SMO_RPT_LAST 5'd19
`define SMO_TRIM_LAST 5'd6
`define SMO_G_LIM 34'sh186a0
`define SMO_A_LIM 34'sh186a0
`endif

// *** logic/smo_line_buf.sv ***
/*
 * Command line buffer: one write port, one read port with registered data.
 * Assumes one clock; read data follow the address by one edge.
 */
`timescale 1ns/1ns
module smo_line_buf (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Write port
   input wire logic we,
   input wire logic [6:0] waddr,
   input wire logic [7:0] wdata,
   // Read port
   input wire logic [6:0] raddr,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:79];

   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata <= 8'h00;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule // smo_line_buf

// *** logic/smo_pkg.sv ***
/*
 * Types of the service command block: states, list modes and the state record.
 * Assumes the widths used by smo_service_cmds.
 */
package smo_pkg;
   typedef enum logic [2:0] {S_IDLE, S_LOAD, S_SCAN, S_EXEC, S_LINE, S_BITS, S_ERR, S_PROMPT} smo_st_e;
   typedef enum logic [1:0] {M_RPT, M_TRIM, M_REF} smo_mode_e;
   typedef struct packed {
      smo_st_e st;
      smo_mode_e md;
      logic [6:0] len;
      logic [6:0] rd;
      logic [7:0] c0;
      logic [7:0] c1;
      logic [7:0] c2;
      logic [1:0] f;
      logic [1:0] l1;
      logic [1:0] l2;
      logic [29:0] acc;
      logic [3:0] nd;
      logic neg;
      logic bad;
      logic bad2;
      logic [5:0][31:0] trim;
      logic [31:0] refv;
      logic [14:0][31:0] word;
      logic [3:0][7:0] stat;
      logic [5:0] mask;
      logic clamp;
      logic [4:0] it;
      logic [4:0] cc;
      logic [2:0] bt;
      logic [3:0] errn;
      logic [3:0] last_err;
      logic [7:0] tx_data;
      logic tx_valid;
      logic rx_ready;
      logic ext_trig;
      logic [2:0] irq_st;
      logic [2:0] irq_mask;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } smo_state_s;
endpackage

// *** logic/smo_service_cmds.sv ***
/*
 * Service command interpreter: single-shot report and trim offset command
 * over a byte stream, with APB registers and one interrupt.
 * Assumes a UART outside on pclk delivering and taking whole bytes.
 */
// Local design decisions: register access over APB and the register offsets.
// Notes on behaviour
// - 'a' CR prints the latest sample
// - report words, status bytes, timing, counter, latency
// - status set bits give NOT OK, listed
// - unknown command letter gives E001
// - extra characters after 'a' give E002
// - one value sets all six trims
// - value and sensor set three trims
// - value, sensor, axis adds to one trim
// - second parameter r stores reference tag
// - sensor selector g or a only
// - axis selector x, y or z only
// - out of range trims clamp, then E008
// - wrong parameter count or comma gives E002
// - invalid parameter value gives E003
// - echo input, CR executes, BS deletes
// - space then commas separate parameters
// - CR then '>' when ready
// - single-shot refused under external trigger
`timescale 1ns/1ns
`include "smo_cfg.svh"
module smo_service_cmds import smo_pkg::*; (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Received bytes
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   output logic rx_ready,
   // Transmitted bytes
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   // Background samples
   input wire logic samp_valid,
   input wire logic [14:0][31:0] samp_word,
   input wire logic [3:0][7:0] samp_stat,
   // Interrupt
   output logic irq
);
   smo_state_s s;
   smo_state_s n;
   logic mem_we;
   logic [7:0] c;
   logic [7:0] ch;
   logic [7:0] lbl;
   logic [31:0] val;
   logic [47:0] vdt;
   logic [4:0] llen;
   logic [4:0] m;
   logic [4:0] kk;
   logic [2:0] ev;
   logic [2:0] clr;
   logic [5:0] msk;
   logic [33:0] vs;
   logic [33:0] t;
   logic [33:0] lim;
   logic [31:0] rdv;
   logic is_stat;
   logic hd;
   logic fin;
   logic fail;
   logic ok_v;
   logic hit;

   // ************************************************************
   // Line buffer
   // ************************************************************
   smo_line_buf u_buf (
      .pclk(pclk),
      .presetn(presetn),
      .we(mem_we),
      .waddr(s.len),
      .wdata(rx_data),
      .raddr(n.rd),
      .rdata(c)
   );

   function automatic logic [4:0] rpt_map(input logic [4:0] it);
      unique case (it)
         5'd3: return 5'h10;
         5'd7: return 5'h11;
         5'd11, 5'd15: return 5'h12;
         5'd17: return 5'h13;
         5'd16: return 5'h0c;
         5'd18: return 5'h0d;
         5'd19: return 5'h0e;
         default: return 5'(it - (it >> 2));
      endcase
   endfunction

   function automatic logic [7:0] hexc(input logic [3:0] v);
      return (v < 4'ha) ? 8'h30 + 8'(v) : 8'h57 + 8'(v);
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      n = s;
      mem_we = 1'b0;
      ev = 3'h0;
      clr = 3'h0;
      fin = 1'b0;
      fail = 1'b0;
      msk = 6'h00;
      t = 34'h0;
      lim = 34'h0;
      vs = s.neg ? 34'(-{4'h0, s.acc}) : {4'h0, s.acc};
      m = rpt_map(s.it);
      hd = (s.md != M_RPT) && (s.it == 5'd0);
      is_stat = 1'b0;
      lbl = 8'h41 + 8'(s.it);
      val = 32'h0;
      // Keep the sample stable while it is being reported
      if (samp_valid && !((s.st == S_LINE || s.st == S_BITS) && s.md == M_RPT)) begin
         n.word = samp_word;
         n.stat = samp_stat;
      end
      if (s.tx_valid && tx_ready) begin
         n.tx_valid = 1'b0;
      end
      unique case (s.md)
         M_RPT: begin
            is_stat = m[4];
            val = m[4] ? {24'h0, s.stat[m[1:0]]} : s.word[m[3:0]];
         end
         M_TRIM: begin
            lbl = 8'h2f + 8'(s.it);
            val = s.trim[3'(s.it - 5'd1)];
         end
         default: begin
            lbl = 8'h52;
            val = s.refv;
         end
      endcase
      ok_v = (val[7:0] == 8'h00);
      vdt = ok_v ? {"OK", 32'h0} : "NOT OK";
      llen = is_stat ? (ok_v ? 5'd14 : 5'd18) : 5'd11;
      kk = s.cc - 5'd11;
      // Character of the current line
      if (hd) begin
         llen = 5'd3;
         ch = (s.cc == 5'd0) ? 8'h54 : (s.cc == 5'd1) ? 8'h3a : `SMO_CH_CR;
      end else if (s.cc == 5'd0) begin
         ch = lbl;
      end else if (s.cc == 5'd1) begin
         ch = 8'h3d;
      end else if (s.cc < 5'd10) begin
         ch = is_stat ? {7'h18, val[5'd9 - s.cc]} : hexc(4'(val >> {5'd9 - s.cc, 2'b00}));
      end else if (is_stat && s.cc == 5'd10) begin
         ch = `SMO_CH_SP;
      end else if (is_stat && s.cc < llen - 5'd1) begin
         ch = vdt[6'd47 - {kk[2:0], 3'b000} -: 8];
      end else begin
         ch = `SMO_CH_CR;
      end
      unique case (s.st)
         S_IDLE: begin
            if (rx_valid && s.rx_ready) begin
               n.tx_valid = 1'b1;
               n.tx_data = rx_data;
               if (rx_data == `SMO_CH_CR) begin
                  n.st = S_LOAD;
               end else if (rx_data == `SMO_CH_BS) begin
                  if (s.len != 7'd0) begin
                     n.len = s.len - 7'd1;
                  end
               end else if (s.len != `SMO_BUF_DEPTH) begin
                  mem_we = 1'b1;
                  n.len = s.len + 7'd1;
               end
            end
         end
         S_LOAD: begin
            n.rd = 7'd0;
            n.f = 2'd0;
            n.acc = 30'h0;
            n.nd = 4'h0;
            n.neg = 1'b0;
            n.bad = 1'b0;
            n.bad2 = 1'b0;
            n.l1 = 2'd0;
            n.l2 = 2'd0;
            n.errn = 4'h0;
            n.clamp = 1'b0;
            n.mask = 6'h00;
            n.it = 5'd0;
            n.cc = 5'd0;
            n.st = (s.len == 7'd0) ? S_PROMPT : S_SCAN;
         end
         S_SCAN: begin
            if (s.rd == 7'd0) begin
               n.c0 = c;
            end else if (s.c0 != `SMO_CMD_TRIM) begin
               n.bad2 = 1'b1;
            end else if (s.rd == 7'd1) begin
               n.bad2 = (c != `SMO_CH_SP);
            end else if (c == `SMO_CH_COMMA) begin
               if (s.f == 2'd2) begin
                  n.bad2 = 1'b1;
               end else begin
                  n.f = s.f + 2'd1;
               end
            end else begin
               unique case (s.f)
                  2'd0: begin
                     if (c == `SMO_CH_MINUS && s.nd == 4'h0 && !s.neg) begin
                        n.neg = 1'b1;
                     end else if (c >= 8'h30 && c <= 8'h39 && s.nd != `SMO_MAX_DIGITS) begin
                        n.acc = 30'(s.acc * 30'd10 + 30'(c - 8'h30));
                        n.nd = s.nd + 4'h1;
                     end else begin
                        n.bad = 1'b1;
                     end
                  end
                  2'd1: begin
                     n.c1 = c;
                     n.l1 = (s.l1 == 2'd3) ? s.l1 : s.l1 + 2'd1;
                  end
                  default: begin
                     n.c2 = c;
                     n.l2 = (s.l2 == 2'd3) ? s.l2 : s.l2 + 2'd1;
                  end
               endcase
            end
            n.rd = s.rd + 7'd1;
            if (s.rd == s.len - 7'd1) begin
               n.st = S_EXEC;
            end
         end
         S_EXEC: begin
            n.st = S_LINE;
            n.md = M_TRIM;
            if (s.c0 == `SMO_CMD_SHOT) begin
               if (s.ext_trig) begin
                  n.errn = `SMO_E_UNKNOWN;
               end else if (s.len != 7'd1) begin
                  n.errn = `SMO_E_COUNT;
               end else begin
                  n.md = M_RPT;
               end
            end else if (s.c0 != `SMO_CMD_TRIM) begin
               n.errn = `SMO_E_UNKNOWN;
            end else if (s.len == 7'd1 || s.bad2 || s.nd == 4'h0 || (s.f != 2'd0 && s.l1 == 2'd0) ||
                         (s.f == 2'd2 && (s.l2 == 2'd0 || s.c1 == `SMO_SEL_REF))) begin
               n.errn = `SMO_E_COUNT;
            end else if (s.bad || (s.f != 2'd0 && s.l1 != 2'd1) || (s.f == 2'd2 && s.l2 != 2'd1)) begin
               n.errn = `SMO_E_INVALID;
            end else if (s.f == 2'd1 && s.c1 == `SMO_SEL_REF) begin
               if (s.neg) begin
                  n.errn = `SMO_E_INVALID;
               end else begin
                  n.refv = {2'b00, s.acc};
                  n.md = M_REF;
               end
            end else begin
               if (s.f == 2'd0) begin
                  msk = 6'h3f;
               end else if (s.c1 == `SMO_SEL_GYRO) begin
                  msk = 6'h07;
               end else if (s.c1 == `SMO_SEL_ACC) begin
                  msk = 6'h38;
               end
               if (s.f == 2'd2) begin
                  msk = msk & ((s.c2 == `SMO_AX_X) ? 6'h09 : (s.c2 == `SMO_AX_Y) ? 6'h12 :
                               (s.c2 == `SMO_AX_Z) ? 6'h24 : 6'h00);
               end
               if (msk == 6'h00) begin
                  n.errn = `SMO_E_INVALID;
               end
               n.mask = msk;
               for (int i = 0; i < 6; i++) begin
                  if (msk[i]) begin
                     t = ((s.f == 2'd2) ? {{2{s.trim[i][31]}}, s.trim[i]} : 34'h0) + vs;
                     lim = (i < 3) ? `SMO_G_LIM : `SMO_A_LIM;
                     if ($signed(t) > $signed(lim)) begin
                        t = lim;
                        n.clamp = 1'b1;
                     end else if ($signed(t) < -$signed(lim)) begin
                        t = -lim;
                        n.clamp = 1'b1;
                     end
                     n.trim[i] = t[31:0];
                  end
               end
            end
            fail = (n.errn != 4'h0);
            if (fail) begin
               n.st = S_ERR;
            end else if (n.clamp) begin
               n.errn = `SMO_E_CLAMP;
            end
         end
         S_LINE: begin
            if (s.md == M_TRIM && !hd && !s.mask[3'(s.it - 5'd1)]) begin
               fin = 1'b1;
            end else if (!s.tx_valid) begin
               n.tx_valid = 1'b1;
               n.tx_data = ch;
               n.cc = s.cc + 5'd1;
               if (s.cc == llen - 5'd1) begin
                  n.cc = 5'd0;
                  n.bt = 3'd7;
                  if (is_stat && !ok_v) begin
                     n.st = S_BITS;
                  end else begin
                     fin = 1'b1;
                  end
               end
            end
         end
         S_BITS: begin
            if (!val[s.bt]) begin
               fin = (s.bt == 3'd0);
               n.bt = s.bt - 3'd1;
            end else if (!s.tx_valid) begin
               n.tx_valid = 1'b1;
               n.tx_data = (s.cc < 5'd5) ? 8'(" BIT " >> {5'd4 - s.cc, 3'b000}) :
                           (s.cc == 5'd5) ? 8'h30 + 8'(s.bt) : `SMO_CH_CR;
               n.cc = s.cc + 5'd1;
               if (s.cc == 5'd6) begin
                  n.cc = 5'd0;
                  fin = (s.bt == 3'd0);
                  n.bt = s.bt - 3'd1;
               end
            end
         end
         S_ERR: begin
            if (!s.tx_valid) begin
               n.tx_valid = 1'b1;
               n.tx_data = (s.cc == 5'd0) ? 8'h45 : (s.cc < 5'd3) ? 8'h30 :
                           (s.cc == 5'd3) ? 8'h30 + 8'(s.errn) : `SMO_CH_CR;
               n.cc = s.cc + 5'd1;
               if (s.cc == 5'd4) begin
                  n.cc = 5'd0;
                  n.last_err = s.errn;
                  ev[`SMO_IRQ_ERR_BIT] = 1'b1;
                  ev[`SMO_IRQ_CLAMP_BIT] = s.clamp;
                  n.st = S_PROMPT;
               end
            end
         end
         S_PROMPT: begin
            if (!s.tx_valid) begin
               n.tx_valid = 1'b1;
               n.tx_data = (s.cc == 5'd0) ? `SMO_CH_CR : `SMO_CH_PROMPT;
               n.cc = s.cc + 5'd1;
               if (s.cc == 5'd1) begin
                  n.cc = 5'd0;
                  n.len = 7'd0;
                  ev[`SMO_IRQ_DONE_BIT] = 1'b1;
                  n.st = S_IDLE;
               end
            end
         end
      endcase
      if (fin) begin
         n.it = s.it + 5'd1;
         n.st = S_LINE;
         if ((s.md == M_RPT && s.it == `SMO_RPT_LAST) || (s.md == M_TRIM && s.it == `SMO_TRIM_LAST) ||
             (s.md == M_REF && s.it == 5'd1)) begin
            n.st = (s.errn != 4'h0) ? S_ERR : S_PROMPT;
         end
      end
      // APB: answer prepared in the setup cycle, zero wait states
      hit = 1'b1;
      rdv = 32'h0;
      unique case (paddr)
         `SMO_OFS_CTRL: rdv = {31'h0, s.ext_trig};
         `SMO_OFS_IRQ_ST: rdv = {29'h0, s.irq_st};
         `SMO_OFS_IRQ_MASK: rdv = {29'h0, s.irq_mask};
         `SMO_OFS_REF: rdv = s.refv;
         `SMO_OFS_LAST_ERR: rdv = {28'h0, s.last_err};
         default: begin
            hit = (paddr >= `SMO_OFS_TRIM0) && (paddr <= `SMO_OFS_TRIM5) && (paddr[1:0] == 2'b00);
            rdv = hit ? s.trim[3'((paddr - `SMO_OFS_TRIM0) >> 2)] : 32'h0;
         end
      endcase
      n.pready = psel && !penable;
      n.pslverr = psel && !penable && !hit;
      n.prdata = (psel && !penable) ? rdv : s.prdata;
      if (psel && penable && s.pready && pwrite && !s.pslverr) begin
         unique case (paddr)
            `SMO_OFS_CTRL: n.ext_trig = pwdata[`SMO_CTRL_EXT_BIT];
            `SMO_OFS_IRQ_ST: clr = pwdata[2:0];
            `SMO_OFS_IRQ_MASK: n.irq_mask = pwdata[2:0];
            default: ;
         endcase
      end
      n.irq_st = (s.irq_st & ~clr) | ev;
      n.irq = |(n.irq_st & n.irq_mask);
      n.rx_ready = (n.st == S_IDLE) && !n.tx_valid;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign rx_ready = s.rx_ready;
   assign tx_data = s.tx_data;
   assign tx_valid = s.tx_valid;
   assign irq = s.irq;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_take(logic [7:0] k);
      s.st == S_IDLE && rx_valid && s.rx_ready && rx_data == k;
   endsequence
   sequence s_cr_sent;
      s.st == S_PROMPT && s.cc == 5'd1 && !s.tx_valid && s.tx_data == `SMO_CH_CR;
   endsequence

   a_echo_char: assert property (s.st == S_IDLE && rx_valid && s.rx_ready |=>
      s.tx_valid && s.tx_data == $past(rx_data)) else $error("received byte not echoed");
   a_bs_delete: assert property (s_take(`SMO_CH_BS) and s.len != 7'd0 |=>
      s.len == $past(s.len) - 7'd1) else $error("backspace did not remove a byte");
   a_cr_runs: assert property (s_take(`SMO_CH_CR) |=> s.st == S_LOAD) else $error("CR did not start a command");
   a_prompt_pair: assert property (s_cr_sent |=> s.tx_valid && s.tx_data == `SMO_CH_PROMPT
      ##1 s.st == S_IDLE) else $error("prompt not CR then >");
   a_shot_blocked: assert property (s.st == S_EXEC && s.c0 == `SMO_CMD_SHOT && s.ext_trig |=>
      s.st == S_ERR && s.errn == `SMO_E_UNKNOWN) else $error("single-shot ran under external trigger");
   a_shot_extra: assert property (s.st == S_EXEC && s.c0 == `SMO_CMD_SHOT && !s.ext_trig && s.len != 7'd1
      |=> s.errn == `SMO_E_COUNT) else $error("extra characters not flagged");
   a_unknown_cmd: assert property (s.st == S_EXEC && s.c0 != `SMO_CMD_SHOT && s.c0 != `SMO_CMD_TRIM
      |=> s.st == S_ERR && s.errn == `SMO_E_UNKNOWN) else $error("unknown command not flagged");
   a_trim_limit: assert property ($signed({{2{s.trim[0][31]}}, s.trim[0]}) <= `SMO_G_LIM &&
      $signed({{2{s.trim[3][31]}}, s.trim[3]}) >= -`SMO_A_LIM) else $error("trim beyond limit");
   a_clamp_flag: assert property (s.st == S_EXEC ##1 s.clamp |-> s.errn == `SMO_E_CLAMP)
      else $error("clamp without E008");
   a_stat_verdict: assert property (s.st == S_LINE && s.md == M_RPT && is_stat && s.cc == 5'd11 &&
      !s.tx_valid |=> s.tx_data == ($past(ok_v) ? 8'h4f : 8'h4e)) else $error("wrong status verdict");
   a_all_set: assert property (s.st == S_EXEC ##1 s.md == M_TRIM && s.mask == 6'h3f && !s.clamp |->
      s.trim[0] == s.trim[5] && s.trim[1] == s.trim[4]) else $error("trims not all set alike");
   a_ref_store: assert property (s.st == S_EXEC ##1 s.md == M_REF && s.st == S_LINE |->
      s.refv == {2'b00, s.acc}) else $error("reference tag not stored");
endmodule // smo_service_cmds

// *** verification/smo_host.sv ***
/*
 * Host terminal model: sends command lines byte by byte and collects the
 * echo and answer bytes, stalling the transmit side at random.
 * Assumes the block's byte link on the same clock.
 */
`timescale 1ns/1ns
module smo_host (
   // Clock
   input wire logic pclk,
   // Bytes towards the block
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   // Bytes from the block
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready
);
   byte unsigned got[$];
   initial begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
   end
   // Sink with random stalls
   always @(posedge pclk) begin
      if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_data);
      tx_ready <= ($urandom_range(3) != 0);
   end
   // Each byte held until taken; line closed by carriage return
   task automatic send(input string s);
      int n;
      for (int i = 0; i <= s.len(); i++) begin
         @(posedge pclk);
         rx_data <= (i == s.len()) ? 8'h0d : 8'(s[i]);
         rx_valid <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (rx_ready !== 1'b1 && n < 5000);
         rx_valid <= 1'b0;
         rx_data <= ~rx_data;
      end
   endtask
endmodule // smo_host

// *** verification/smo_service_cmds_tb.sv ***
/*
 * Testbench of the service command block: APB tasks, command lines
 * through the host model, trim model and report formatting.
 * Assumes the design files and smo_host are compiled first.
 */
`timescale 1ns/1ns
`include "smo_cfg.svh"
module smo_service_cmds_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, irq, e, samp_valid = 1'b0;
   logic [7:0] rx_data, tx_data;
   logic rx_valid, rx_ready, tx_valid, tx_ready;
   logic [14:0][31:0] sw = '0;
   logic [3:0][7:0] ss = '0;
   int fails = 0, compares = 0, tr[6], v, lim;
   string resp;
   string es[9] = '{"q", "a 1", "b", "b,5", "b 5,q", "b 5,g,w", "b 5,r,x", "b 1234567890", "b 5,g,x,y"};
   logic [31:0] ec[9] = '{1, 2, 2, 2, 3, 3, 2, 3, 2};
   initial begin
      forever #50 pclk = ~pclk;
   end
   smo_service_cmds smo_service_cmds_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .samp_valid(samp_valid), .samp_word(sw), .samp_stat(ss), .irq(irq));
   smo_host smo_host_i (.pclk(pclk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
   //****************************************
   // Tasks and expectations
   //****************************************
   task automatic end_sim();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chks(input string got, input string exp);
      compares++;
      if (got != exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (pready !== 1'b1) begin
         fails++;
         end_sim();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask
   task automatic chk_trims();
      for (int k = 0; k < 6; k++) rd(`SMO_OFS_TRIM0 + 8'(4 * k), tr[k]);
   endtask
   task automatic cmd(input string s);
      int n;
      smo_host_i.got.delete();
      smo_host_i.send(s);
      n = 0;
      while (!(smo_host_i.got.size() > 1 && smo_host_i.got[$] == 8'h3e && smo_host_i.got[$ - 1] == 8'h0d)) begin
         @(posedge pclk);
         n++;
         if (n > 30000) begin
            fails++;
            end_sim();
         end
      end
      repeat (2) @(posedge pclk);
      resp = "";
      foreach (smo_host_i.got[i]) resp = $sformatf("%s%c", resp, smo_host_i.got[i]);
   endtask
   function automatic string rpt_exp(input logic [14:0][31:0] w, input logic [3:0][7:0] s);
      string t;
      int wi;
      int si;
      t = "a\015";
      wi = 0;
      for (int k = 0; k < 20; k++) begin
         if (k == 3 || k == 7 || k == 11 || k == 15 || k == 17) begin
            si = (k == 3) ? 0 : (k == 7) ? 1 : (k == 17) ? 3 : 2;
            t = $sformatf("%s%c=%b %s\015", t, 8'(8'h41 + k), s[si], (s[si] != 0) ? "NOT OK" : "OK");
            for (int b = 7; b >= 0; b--) if (s[si][b]) t = $sformatf("%s BIT %0d\015", t, b);
         end else begin
            t = $sformatf("%s%c=%h\015", t, 8'(8'h41 + k), w[wi]);
            wi++;
         end
      end
      return {t, "\015>"};
   endfunction
   //****************************************
   // Main sequence
   //****************************************
   initial begin
      v = $urandom(73);
      lim = int'(`SMO_G_LIM);
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`SMO_OFS_CTRL, 32'h0);
      rd(`SMO_OFS_IRQ_MASK, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(e, 1'b1);
      cmd("b 0");
      tr = '{default: 0};
      chk_trims();
      v = $urandom_range(50000) + 2;
      cmd($sformatf("b %0d,g", v));
      for (int k = 0; k < 3; k++) begin
         tr[k] = lim;
         cmd($sformatf("b 99999,g,%c", 8'h78 + k));
         chks(resp, $sformatf("b 99999,g,%c\015T:\015%0d=%h\015E008\015\015>", 8'h78 + k, k, tr[k]));
         v = $urandom_range(2000) - 1000;
         tr[k + 3] += v;
         cmd($sformatf("b %0d,a,%c", v, 8'h78 + k));
         chks(resp, $sformatf("b %0d,a,%c\015T:\015%0d=%h\015\015>", v, 8'h78 + k, k + 3, tr[k + 3]));
      end
      rd(`SMO_OFS_LAST_ERR, 32'h8);
      rd(`SMO_OFS_IRQ_ST, 32'h7);
      chk_trims();
      cmd($sformatf("b 79%c,a", 8'h08));
      cmd("b -200000,g");
      tr = '{-lim, -lim, -lim, 7, 7, 7};
      chk_trims();
      cmd("b 43639,r");
      chks(resp, "b 43639,r\015T:\015R=0000aa77\015\015>");
      rd(`SMO_OFS_REF, 32'd43639);
      for (int k = 0; k < 9; k++) begin
         cmd(es[k]);
         chks(resp, $sformatf("%s\015E00%0d\015\015>", es[k], ec[k]));
         rd(`SMO_OFS_LAST_ERR, ec[k]);
      end
      chk_trims();
      for (int k = 0; k < 15; k++) sw[k] <= $urandom;
      ss <= {8'($urandom), 8'($urandom), 8'($urandom), 8'h14};
      samp_valid <= 1'b1;
      @(posedge pclk);
      samp_valid <= 1'b0;
      cmd("a");
      chks(resp, rpt_exp(sw, ss));
      apb(1'b1, `SMO_OFS_CTRL, 32'h1);
      cmd("a");
      rd(`SMO_OFS_LAST_ERR, 32'h1);
      apb(1'b1, `SMO_OFS_CTRL, 32'h0);
      apb(1'b1, `SMO_OFS_IRQ_ST, 32'h7);
      apb(1'b1, `SMO_OFS_IRQ_MASK, 32'h5);
      chk(irq, 1'b0);
      cmd("b 0,a");
      chk(irq, 1'b1);
      rd(`SMO_OFS_IRQ_ST, 32'h1);
      apb(1'b1, `SMO_OFS_IRQ_ST, 32'h1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      end_sim();
   end
endmodule // smo_service_cmds_tb
